// file: rtl/scr_config_regs.sv
// System configuration registers: DMA request steering, pin options, boot mode and interrupt source select.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
// How it works
// - Bit 19 gives pin B9 high drive
// - Bit 12 moves timer16 requests channel 0 to 1
// - Bit 11 moves timer15 requests channel 2 to 3
// - Bit 10 moves serial0 receive channel 2 to 4
// - Bit 9 moves serial0 transmit channel 1 to 3
// - Bit 8 moves converter request channel 0 to 1
// - Bit 4 swaps pins A9/A10 for A11/A12
// - Boot field: boot pin, inverted option bit
// - Boot code x0 flash, 01 system, 11 SRAM
// - Line 3 source: A on X000, B on X001
// - Line 2 source in bits 11:8
// - Line 1 source in bits 7:4, F on X101
// - Line 0 source in bits 3:0, F on X101
// - Boot pin sampled on fourth edge after reset
module scr_config_regs
  import scr_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot straps.
  input wire logic boot_select_pin,
  input wire logic boot1_option_inverted,
  // DMA requests from peripherals.
  input wire logic timer16_ch1_req,
  input wire logic timer16_up_req,
  input wire logic timer15_ch1_req,
  input wire logic timer15_up_req,
  input wire logic serial0_rx_req,
  input wire logic serial0_tx_req,
  input wire logic converter_req,
  // DMA requests to the controller, one bit per channel.
  output logic [SCR_DMA_CHANNELS-1:0] dma_chan_req,
  // Pin control.
  output logic port_b_pin9_high_drive_en,
  output logic port_b_pin9_speed_bypass,
  output logic small_package_pin_pair_swap,
  // Interrupt source pins and selected lines.
  input wire logic [SCR_IRQ_LINES-1:0] port_a_pins,
  input wire logic [SCR_IRQ_LINES-1:0] port_b_pins,
  input wire logic [1:0] port_f_pins,
  output logic [SCR_IRQ_LINES-1:0] irq_line
);

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  function automatic logic hit_cfg0(input logic [SCR_ADDR_W-1:0] a);
    return a == SCR_OFF_CONFIG_ZERO;
  endfunction

  function automatic logic hit_irq(input logic [SCR_ADDR_W-1:0] a);
    return a == SCR_OFF_IRQ_SRC_LOW;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------
  logic boot_pin_s1_q, boot_pin_s2_q;
  logic [SCR_IRQ_LINES-1:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic [1:0] pf_s1_q, pf_s2_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_pin_s1_q <= 1'b0;
      boot_pin_s2_q <= 1'b0;
      pa_s1_q <= '0;
      pa_s2_q <= '0;
      pb_s1_q <= '0;
      pb_s2_q <= '0;
      pf_s1_q <= '0;
      pf_s2_q <= '0;
    end else begin
      boot_pin_s1_q <= boot_select_pin;
      boot_pin_s2_q <= boot_pin_s1_q;
      pa_s1_q <= port_a_pins;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_pins;
      pb_s2_q <= pb_s1_q;
      pf_s1_q <= port_f_pins;
      pf_s2_q <= pf_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // APB access.
  // ----------------------------------------------------------------
  // One wait state per transfer so that read data and error both come from registers.
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] cfg0_q, cfg0_d, irq_src_q, irq_src_d;
  logic [1:0] boot_mode_q, boot_mode_d;
  logic access, wr_fire;

  assign access = psel && penable && !pready_q;
  assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb begin
    pready_d = access;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (access) begin
      prdata_d = 32'h00000000;
      if (hit_cfg0(paddr)) begin
        prdata_d = (cfg0_q & SCR_CFG0_WMASK) | {30'h00000000, boot_mode_q};
      end else if (hit_irq(paddr)) begin
        prdata_d = irq_src_q & SCR_IRQ_WMASK;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= SCR_RESET_ZERO;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  // Reserved bits are masked off on write; software should keep them zero anyway.
  always_comb begin
    cfg0_d = cfg0_q;
    irq_src_d = irq_src_q;
    if (wr_fire && hit_cfg0(paddr)) begin
      cfg0_d = pwdata & SCR_CFG0_WMASK;
    end
    if (wr_fire && hit_irq(paddr)) begin
      irq_src_d = pwdata & SCR_IRQ_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg0_q <= SCR_RESET_ZERO;
      irq_src_q <= SCR_RESET_ZERO;
    end else begin
      cfg0_q <= cfg0_d;
      irq_src_q <= irq_src_d;
    end
  end

  assign port_b_pin9_high_drive_en = cfg0_q[SCR_BIT_PB9_HIGH_DRIVE];
  assign port_b_pin9_speed_bypass = cfg0_q[SCR_BIT_PB9_HIGH_DRIVE];
  assign small_package_pin_pair_swap = cfg0_q[SCR_BIT_PIN_PAIR_SWAP];

  // ----------------------------------------------------------------
  // Boot mode capture.
  // ----------------------------------------------------------------
  // Bit 0 follows the boot pin, bit 1 is the inverted option bit, so
  // x0 reads as flash, 01 as system memory and 11 as SRAM.
  scr_boot_state_t boot_state_q, boot_state_d;
  logic [2:0] boot_cnt_q, boot_cnt_d;

  always_comb begin
    boot_state_d = boot_state_q;
    boot_cnt_d = boot_cnt_q;
    boot_mode_d = boot_mode_q;
    case (boot_state_q)
      SCR_BOOT_COUNT: begin
        if (boot_cnt_q == SCR_BOOT_LAST_CNT) begin
          boot_mode_d[SCR_BIT_BOOT_LSB] = boot_pin_s2_q;
          boot_mode_d[SCR_BIT_BOOT_MSB] = ~boot1_option_inverted;
          boot_state_d = SCR_BOOT_HELD;
        end else begin
          boot_cnt_d = 3'(boot_cnt_q + 3'h1);
        end
      end
      SCR_BOOT_HELD: begin
        boot_state_d = SCR_BOOT_HELD;
      end
      default: begin
        boot_state_d = SCR_BOOT_COUNT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      boot_state_q <= SCR_BOOT_COUNT;
      boot_cnt_q <= 3'h0;
      boot_mode_q <= 2'h0;
    end else begin
      boot_state_q <= boot_state_d;
      boot_cnt_q <= boot_cnt_d;
      boot_mode_q <= boot_mode_d;
    end
  end

  // ----------------------------------------------------------------
  // DMA request steering.
  // ----------------------------------------------------------------
  logic [SCR_DMA_CHANNELS-1:0] dma_q, dma_d;
  logic t16_req, t15_req;

  assign t16_req = timer16_ch1_req || timer16_up_req;
  assign t15_req = timer15_ch1_req || timer15_up_req;

  always_comb begin
    dma_d = '0;
    dma_d[cfg0_q[SCR_BIT_TIMER16_STEER] ? SCR_DMA_CH1 : SCR_DMA_CH0] |= t16_req;
    dma_d[cfg0_q[SCR_BIT_TIMER15_STEER] ? SCR_DMA_CH3 : SCR_DMA_CH2] |= t15_req;
    dma_d[cfg0_q[SCR_BIT_SERIAL0_RX_STEER] ? SCR_DMA_CH4 : SCR_DMA_CH2] |= serial0_rx_req;
    dma_d[cfg0_q[SCR_BIT_SERIAL0_TX_STEER] ? SCR_DMA_CH3 : SCR_DMA_CH1] |= serial0_tx_req;
    dma_d[cfg0_q[SCR_BIT_CONVERTER_STEER] ? SCR_DMA_CH1 : SCR_DMA_CH0] |= converter_req;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dma_q <= '0;
    end else begin
      dma_q <= dma_d;
    end
  end

  assign dma_chan_req = dma_q;

  // ----------------------------------------------------------------
  // Interrupt line source select.
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SCR_IRQ_LINES; gi++) begin : g_line
      scr_irq_line_mux #(
        .HAS_PORT_F(gi < 2)
      ) u_mux (
        .clk(clk),
        .srst(srst),
        .src_code(irq_src_q[gi*SCR_SRC_W +: SCR_SRC_W]),
        .pin_port_a(pa_s2_q[gi]),
        .pin_port_b(pb_s2_q[gi]),
        .pin_port_f(gi < 2 ? pf_s2_q[gi % 2] : 1'b0),
        .line_q(irq_line[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_last_count;
    boot_state_q == SCR_BOOT_COUNT && boot_cnt_q == SCR_BOOT_LAST_CNT;
  endsequence

  sequence s_cfg0_write;
    wr_fire && hit_cfg0(paddr);
  endsequence

  AST_PB9_DRIVE: assert property (s_cfg0_write |=> port_b_pin9_high_drive_en == $past(pwdata[19]) &&
    port_b_pin9_speed_bypass == port_b_pin9_high_drive_en)
    else $error("High drive enable does not follow bit 19.");
  AST_TIMER16_STEER: assert property (t16_req |=> dma_q[$past(cfg0_q[SCR_BIT_TIMER16_STEER]) ? 1 : 0])
    else $error("Timer 16 request on wrong channel.");
  AST_TIMER15_STEER: assert property (t15_req |=> dma_q[$past(cfg0_q[SCR_BIT_TIMER15_STEER]) ? 3 : 2])
    else $error("Timer 15 request on wrong channel.");
  AST_SERIAL_RX_STEER: assert property (serial0_rx_req |=>
    dma_q[$past(cfg0_q[SCR_BIT_SERIAL0_RX_STEER]) ? 4 : 2])
    else $error("Serial receive request on wrong channel.");
  AST_SERIAL_TX_STEER: assert property (serial0_tx_req |=>
    dma_q[$past(cfg0_q[SCR_BIT_SERIAL0_TX_STEER]) ? 3 : 1])
    else $error("Serial transmit request on wrong channel.");
  AST_CONVERTER_STEER: assert property (converter_req |=>
    dma_q[$past(cfg0_q[SCR_BIT_CONVERTER_STEER]) ? 1 : 0])
    else $error("Converter request on wrong channel.");
  AST_PIN_SWAP: assert property (s_cfg0_write |=> small_package_pin_pair_swap == $past(pwdata[4]))
    else $error("Pin pair swap does not follow bit 4.");
  AST_BOOT_CAPTURE: assert property (s_last_count |=> boot_mode_q == {~$past(boot1_option_inverted),
    $past(boot_pin_s2_q)} && boot_state_q == SCR_BOOT_HELD)
    else $error("Boot mode not captured from pin and option bit.");
  AST_BOOT_FOURTH_EDGE: assert property ($fell(srst) |-> (boot_state_q == SCR_BOOT_COUNT) [*4] ##1
    (boot_state_q == SCR_BOOT_HELD))
    else $error("Boot pin not sampled on the fourth edge.");
  AST_BOOT_STABLE: assert property (boot_state_q == SCR_BOOT_HELD |=> $stable(boot_mode_q))
    else $error("Boot mode changed after capture.");
  AST_APB_READY: assert property (access |=> pready_q ##1 !pready_q)
    else $error("Ready not raised for exactly one cycle.");

endmodule

// file: rtl/scr_irq_line_mux.sv
// Selects the port pin that drives one external interrupt line.
`timescale 1ns/10ps
module scr_irq_line_mux
  import scr_pkg::*;
#(
  parameter bit HAS_PORT_F = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Source code and candidate pins, already synchronised.
  input wire logic [SCR_SRC_W-1:0] src_code,
  input wire logic pin_port_a,
  input wire logic pin_port_b,
  input wire logic pin_port_f,
  // Selected line.
  output logic line_q
);

  logic line_d;

  // ----------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------
  // Only the low three bits decode; reserved codes hold the line low
  // so that no stray pin can raise an interrupt.
  always_comb begin
    line_d = 1'b0;
    if (src_code[2:0] == SCR_SRC_PORT_A) begin
      line_d = pin_port_a;
    end else if (src_code[2:0] == SCR_SRC_PORT_B) begin
      line_d = pin_port_b;
    end else if (HAS_PORT_F && src_code[2:0] == SCR_SRC_PORT_F) begin
      line_d = pin_port_f;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      line_q <= 1'b0;
    end else begin
      line_q <= line_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_LINE_PORT_A: assert property ((src_code[2:0] == SCR_SRC_PORT_A) |=> line_q == $past(pin_port_a))
    else $error("Line does not follow port A pin.");
  AST_LINE_PORT_B: assert property ((src_code[2:0] == SCR_SRC_PORT_B) |=> line_q == $past(pin_port_b))
    else $error("Line does not follow port B pin.");
  AST_LINE_RESERVED: assert property ((src_code[2:0] != SCR_SRC_PORT_A && src_code[2:0] != SCR_SRC_PORT_B &&
    !(HAS_PORT_F && src_code[2:0] == SCR_SRC_PORT_F)) |=> !line_q)
    else $error("Reserved source code drives the line.");
  AST_LINE_PORT_F: assert property ((HAS_PORT_F && src_code[2:0] == SCR_SRC_PORT_F) |=>
    line_q == $past(pin_port_f))
    else $error("Line does not follow port F pin.");

endmodule

// file: rtl/scr_pkg.sv
// Package holding the register map, field positions and timing counts of the system configuration registers.
package scr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB).
  // ----------------------------------------------------------------
  localparam int SCR_ADDR_W = 8;
  localparam logic [7:0] SCR_OFF_CONFIG_ZERO = 8'h00;
  localparam logic [7:0] SCR_OFF_IRQ_SRC_LOW = 8'h08;

  // ----------------------------------------------------------------
  // Field positions in system_config_zero.
  // ----------------------------------------------------------------
  localparam int SCR_BIT_PB9_HIGH_DRIVE = 19;
  localparam int SCR_BIT_TIMER16_STEER = 12;
  localparam int SCR_BIT_TIMER15_STEER = 11;
  localparam int SCR_BIT_SERIAL0_RX_STEER = 10;
  localparam int SCR_BIT_SERIAL0_TX_STEER = 9;
  localparam int SCR_BIT_CONVERTER_STEER = 8;
  localparam int SCR_BIT_PIN_PAIR_SWAP = 4;
  localparam int SCR_BIT_BOOT_LSB = 0;
  localparam int SCR_BIT_BOOT_MSB = 1;

  // Writable bits of each register; everything else reads zero, except the boot mode in bits 1:0 of system_config_zero.
  localparam logic [31:0] SCR_CFG0_WMASK = 32'h00081F10;
  localparam logic [31:0] SCR_IRQ_WMASK = 32'h0000FFFF;
  localparam logic [31:0] SCR_RESET_ZERO = 32'h00000000;

  // ----------------------------------------------------------------
  // Interrupt line source codes; the top bit of each field is ignored.
  // ----------------------------------------------------------------
  localparam int SCR_IRQ_LINES = 4;
  localparam int SCR_SRC_W = 4;
  localparam logic [2:0] SCR_SRC_PORT_A = 3'h0;
  localparam logic [2:0] SCR_SRC_PORT_B = 3'h1;
  localparam logic [2:0] SCR_SRC_PORT_F = 3'h5;

  // ----------------------------------------------------------------
  // DMA channels and boot sampling.
  // ----------------------------------------------------------------
  localparam int SCR_DMA_CHANNELS = 5;
  localparam int SCR_DMA_CH0 = 0;
  localparam int SCR_DMA_CH1 = 1;
  localparam int SCR_DMA_CH2 = 2;
  localparam int SCR_DMA_CH3 = 3;
  localparam int SCR_DMA_CH4 = 4;

  // The boot pin is taken on the fourth rising edge after reset release.
  localparam int SCR_BOOT_SAMPLE_EDGE = 4;
  localparam logic [2:0] SCR_BOOT_LAST_CNT = 3'(SCR_BOOT_SAMPLE_EDGE - 1);

  typedef enum logic [1:0] {
    SCR_BOOT_COUNT = 2'b01,
    SCR_BOOT_HELD = 2'b10
  } scr_boot_state_t;

endpackage

// file: testbench/scr_far_side.sv
// Far-side model: peripherals raising DMA requests and the port pins feeding the interrupt source selection.
`timescale 1ns/10ps
module scr_far_side (
  // Clock and wanted levels.
  input wire logic clk,
  input wire logic [6:0] req_want,
  input wire logic [9:0] pin_want,
  // Peripheral requests {converter, tx, rx, t15 up, t15 ch1, t16 up, t16 ch1}.
  output logic [6:0] req_q = 7'h00,
  // Port pins {port f [1:0], port b [3:0], port a [3:0]}.
  output logic [9:0] pin_q = 10'h000
);
  // Levels move only on a rising edge, as peripherals on the same clock would, so no edge sees a half change.
  always_ff @(posedge clk) begin
    req_q <= req_want;
    pin_q <= pin_want;
  end
endmodule

// file: testbench/tb_scr_config_regs.sv
// Self-checking testbench of the system configuration registers.
`timescale 1ns/10ps
module tb_scr_config_regs import scr_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [SCR_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hd_en, spd_byp, swap;
  logic boot_pin = 1'b0;
  logic boot_opt = 1'b0;
  logic [6:0] req_want = 7'h00;
  logic [6:0] req;
  logic [9:0] pin_want = 10'h000;
  logic [9:0] pin;
  logic [SCR_DMA_CHANNELS-1:0] dma_chan_req;
  logic [SCR_IRQ_LINES-1:0] irq_line;
  logic [33:0] exp_q[$];
  int num_errors = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  scr_far_side far_u (.clk(clk), .req_want(req_want), .pin_want(pin_want), .req_q(req), .pin_q(pin));

  scr_config_regs dut_u (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_select_pin(boot_pin), .boot1_option_inverted(boot_opt),
    .timer16_ch1_req(req[0]), .timer16_up_req(req[1]), .timer15_ch1_req(req[2]), .timer15_up_req(req[3]),
    .serial0_rx_req(req[4]), .serial0_tx_req(req[5]), .converter_req(req[6]), .dma_chan_req(dma_chan_req),
    .port_b_pin9_high_drive_en(hd_en), .port_b_pin9_speed_bypass(spd_byp),
    .small_package_pin_pair_swap(swap), .port_a_pins(pin[3:0]), .port_b_pins(pin[7:4]),
    .port_f_pins(pin[9:8]), .irq_line(irq_line));

  // ----------------------------------------------------------------
  // Comparison, closing report and bus master.
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
    n_tests++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // For a read, d is the expected data; the note goes in the queue before the request starts.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    exp_q.push_back({!wr, err, d});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic do_reset(input logic pin_v, input logic opt_v);
    @(posedge clk);
    srst <= 1'b1;
    boot_pin <= pin_v;
    boot_opt <= opt_v;
    repeat (2) @(posedge clk);
    check({18'h0, pready, pslverr, hd_en, spd_byp, swap, dma_chan_req, irq_line}, 32'h0, "outputs in reset");
    check(prdata, 32'h0, "read data in reset");
    srst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // Every completed transfer takes the oldest note off the queue.
  always @(posedge clk) begin
    logic [33:0] mon_e;
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0, "answer without request");
      end else begin
        mon_e = exp_q.pop_front();
        check({31'h0, pslverr}, {31'h0, mon_e[32]}, "error response");
        if (mon_e[33]) check(prdata, mon_e[31:0], "read data");
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] cfg, v, boot_v;
    logic [4:0] e;
    logic [3:0] le;
    int i, n;
    i = $urandom(72);
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    for (i = 0; i < 4; i++) begin
      do_reset(i[0], i[1]);
      apb(1'b0, SCR_OFF_CONFIG_ZERO, {30'h0, !i[1], i[0]}, 1'b0);
    end
    boot_v = 32'h1;
    $display("test boot field done");
    for (i = 0; i < 10; i++) begin
      cfg = (i == 0) ? 32'h0 : (i == 1) ? SCR_CFG0_WMASK : $urandom & SCR_CFG0_WMASK;
      apb(1'b1, SCR_OFF_CONFIG_ZERO, cfg, 1'b0);
      apb(1'b0, SCR_OFF_CONFIG_ZERO, cfg | boot_v, 1'b0);
      req_want <= 7'($urandom);
      repeat (4) @(posedge clk);
      e = 5'h00;
      e[cfg[SCR_BIT_TIMER16_STEER] ? SCR_DMA_CH1 : SCR_DMA_CH0] |= req_want[0] | req_want[1];
      e[cfg[SCR_BIT_TIMER15_STEER] ? SCR_DMA_CH3 : SCR_DMA_CH2] |= req_want[2] | req_want[3];
      e[cfg[SCR_BIT_SERIAL0_RX_STEER] ? SCR_DMA_CH4 : SCR_DMA_CH2] |= req_want[4];
      e[cfg[SCR_BIT_SERIAL0_TX_STEER] ? SCR_DMA_CH3 : SCR_DMA_CH1] |= req_want[5];
      e[cfg[SCR_BIT_CONVERTER_STEER] ? SCR_DMA_CH1 : SCR_DMA_CH0] |= req_want[6];
      check({27'h0, dma_chan_req}, {27'h0, e}, "dma steering");
      check({29'h0, hd_en, spd_byp, swap}, {29'h0, cfg[19], cfg[19], cfg[4]}, "pin control");
    end
    req_want <= 7'h00;
    $display("test dma steering and pin control done");
    apb(1'b1, 8'h04, 32'h00001F10, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 1'b1);
    apb(1'b0, SCR_OFF_CONFIG_ZERO, cfg | boot_v, 1'b0);
    $display("test unmapped address done");
    for (i = 0; i < 16; i++) begin
      v = {16'h0, {4{i[3:0]}}};
      apb(1'b1, SCR_OFF_IRQ_SRC_LOW, v, 1'b0);
      apb(1'b0, SCR_OFF_IRQ_SRC_LOW, v, 1'b0);
      pin_want <= 10'($urandom);
      repeat (6) @(posedge clk);
      for (n = 0; n < 4; n++) begin
        le[n] = (i[2:0] == SCR_SRC_PORT_A) ? pin_want[n] : (i[2:0] == SCR_SRC_PORT_B) ? pin_want[4+n] :
          (i[2:0] == SCR_SRC_PORT_F && n < 2) ? pin_want[8+n] : 1'b0;
      end
      check({28'h0, irq_line}, {28'h0, le}, "interrupt source");
    end
    $display("test interrupt source select done");
    test_done();
  end
endmodule
